// File: dv/anpc_far_model.sv
/*
  Far side model: board logic on the shared loopback/user pin and the
  repeater watching the packet compression pin.
  Assumes both pins are sampled on clk_i and have no pull resistor.
*/
`timescale 1ns/1ns
module anpc_far_model (
  // clock
  input  wire logic  clk_i,
  // pins from the block
  input  wire logic  lb_val_i,
  input  wire logic  lb_oe_i,
  input  wire logic  comp_val_i,
  input  wire logic  comp_oe_i,
  // resolved wire levels and shortened packet count
  output logic       lb_wire_o,
  output logic       comp_wire_o,
  output logic [7:0] shortened_o
);
  logic       lb_last_q   = 1'b0;
  logic       comp_last_q = 1'b0;
  logic [7:0] short_q     = 8'h00;

  // a floating pin shows the inverse of its last level, never a hold
  assign lb_wire_o   = lb_oe_i ? lb_val_i : ~lb_last_q;
  assign comp_wire_o = comp_oe_i ? comp_val_i : ~comp_last_q;
  assign shortened_o = short_q;

  // remember last driven levels
  always_ff @(posedge clk_i) begin
    if (lb_oe_i) begin
      lb_last_q <= lb_val_i;
    end
    if (comp_oe_i) begin
      comp_last_q <= comp_val_i;
    end
  end

  // repeater shortens packets while compression is driven high
  always_ff @(posedge clk_i) begin
    if (comp_oe_i && comp_val_i) begin
      short_q <= short_q + 8'h01;
    end
  end
endmodule

// File: dv/anpc_pin_ctrl_bench.sv
/*
  Bench for the auxiliary pin control: reset and loopback checks, a table of
  compression cases, then hand tests of user output, clock enable and a second reset.
  Assumes the far side model resolves both pin levels.
*/
`timescale 1ns/1ns
module anpc_pin_ctrl_bench
  import anpc_pkg::*;
;
  logic             clk_i    = 1'b0;
  logic             rst_n_i  = 1'b0;
  logic             clk_en_i = 1'b1;
  logic             cfg_wr   = 1'b0;
  logic             cfg2_wr  = 1'b0;
  logic [CFG_W-1:0] cfg_data = 16'h0000;
  logic             loop_req = 1'b0;
  logic             master   = 1'b0;
  logic             mvalid   = 1'b0;
  logic             mhit     = 1'b0;
  logic             lb_out, lb_oe, lb_int, pc_out, pc_oe;
  logic             lb_wire, pc_wire;
  logic [CFG_W-1:0] reg1, reg2;
  logic [7:0]       shortened;
  int               num_errors = 0;
  int               n_checks   = 0;
  int               cycles     = 0;
  // rows: second config word, match hit, expected compression level
  logic [17:0]      rows [8] = '{
    {16'h0002, 2'b11}, {16'h0002, 2'b00}, {16'h0004, 2'b10},
    {16'h0004, 2'b01}, {16'h0006, 2'b11}, {16'h0006, 2'b01},
    {16'h0000, 2'b10}, {16'h0000, 2'b00}};

  anpc_pin_ctrl DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .data_config_wr_i(cfg_wr), .data_config_two_wr_i(cfg2_wr),
    .config_data_i(cfg_data), .line_codec_loop_i(loop_req),
    .bus_master_i(master), .match_valid_i(mvalid),
    .match_hit_i(mhit), .loopback_indicator_out_o(lb_out),
    .loopback_indicator_oe_o(lb_oe), .loopback_internal_o(lb_int),
    .packet_compress_out_o(pc_out), .packet_compress_oe_o(pc_oe),
    .data_config_reg_o(reg1), .data_config_reg_two_o(reg2));

  anpc_far_model far (
    .clk_i(clk_i), .lb_val_i(lb_out), .lb_oe_i(lb_oe),
    .comp_val_i(pc_out), .comp_oe_i(pc_oe), .lb_wire_o(lb_wire),
    .comp_wire_o(pc_wire), .shortened_o(shortened));

  // 100 ns period
  always #50 clk_i = ~clk_i;

  // hang guard, well above the roughly 90 cycles the run needs
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [CFG_W-1:0] exp,
                     input logic [CFG_W-1:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // settle just after an edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // one-cycle write strobe, sel 1 picks the second word
  task automatic wr(input logic sel, input logic [CFG_W-1:0] d);
    @(posedge clk_i);
    cfg_wr   <= ~sel;
    cfg2_wr  <= sel;
    cfg_data <= d;
    @(posedge clk_i);
    cfg_wr  <= 1'b0;
    cfg2_wr <= 1'b0;
  endtask

  task automatic match(input logic hit);
    @(posedge clk_i);
    mvalid <= 1'b1;
    mhit   <= hit;
    @(posedge clk_i);
    mvalid <= 1'b0;
    #1;
  endtask

  initial begin
    step(6);
    chk("lb_oe", 0, lb_oe);
    chk("pc_oe", 0, pc_oe);
    chk("reg1", CFG_RST, reg1);
    chk("reg2", CFG2_RST, reg2);
    @(posedge clk_i);
    rst_n_i  <= 1'b1;
    loop_req <= 1'b1;
    step(4);
    chk("lb_oe", 0, lb_oe);
    wr(0, 16'h0000);
    step(3);
    chk("lb_wire", 1, lb_wire);
    chk("lb_int", 1, lb_int);
    chk("pc_oe", 0, pc_oe);
    // compression table, each row rewrites the second word
    foreach (rows[i]) begin
      wr(1, rows[i][17:2]);
      match(rows[i][1]);
      chk("pc_wire", rows[i][0], pc_wire);
      chk("pc_oe", 1, pc_oe);
    end
    chk("shortened", 16'h0010, {8'h00, shortened});
    // user mode floats until mastership, which then sticks
    @(posedge clk_i);
    loop_req <= 1'b0;
    wr(1, 16'h1000);
    wr(0, 16'h8000);
    step(3);
    chk("lb_oe", 0, lb_oe);
    chk("reg2", 16'h1000, reg2);
    @(posedge clk_i);
    master <= 1'b1;
    step(3);
    chk("lb_wire", 1, lb_wire);
    chk("lb_oe", 1, lb_oe);
    @(posedge clk_i);
    master <= 1'b0;
    wr(1, 16'h0000);
    step(3);
    chk("lb_oe", 1, lb_oe);
    chk("lb_wire", 0, lb_wire);
    // clearing the select bit returns the loopback indicator
    @(posedge clk_i);
    loop_req <= 1'b1;
    wr(0, 16'h0000);
    step(3);
    chk("lb_wire", 1, lb_wire);
    chk("lb_out", 1, lb_out);
    // strobes are ignored with the clock enable low
    @(posedge clk_i);
    clk_en_i <= 1'b0;
    wr(0, 16'h8000);
    @(posedge clk_i);
    clk_en_i <= 1'b1;
    step(1);
    chk("reg1", 16'h0000, reg1);
    // second reset in mid-run floats both pins again
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    step(2);
    chk("lb_oe", 0, lb_oe);
    chk("pc_oe", 0, pc_oe);
    chk("reg1", CFG_RST, reg1);
    // release with mastership already up: pin floats until written
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    master  <= 1'b1;
    step(2);
    chk("lb_oe", 0, lb_oe);
    chk("pc_oe", 0, pc_oe);
    wr(0, 16'h8000);
    step(3);
    chk("lb_oe", 1, lb_oe);
    chk("lb_out", 0, lb_out);
    summarize();
  end
endmodule

// File: verilog/anpc_pin_ctrl.sv
/*
  Auxiliary network pin control: holds both configuration words, the
  written flags and the first-mastership flag, drives the packet
  compression pin and instantiates the shared loopback/user pin.
  Assumes write strobes, data, loopback request, bus master and match
  result all come from logic on clk_i, so none are synchronised.
*/
`timescale 1ns/1ns
module anpc_pin_ctrl
  import anpc_pkg::*;
(
  // clock, reset, enable
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_en_i,
  // configuration writes
  input  wire logic             data_config_wr_i,
  input  wire logic             data_config_two_wr_i,
  input  wire logic [CFG_W-1:0] config_data_i,
  // mode and bus state
  input  wire logic             line_codec_loop_i,
  input  wire logic             bus_master_i,
  // address filter result
  input  wire logic             match_valid_i,
  input  wire logic             match_hit_i,
  // shared loopback / user pin and internal loopback copy
  output logic                  loopback_indicator_out_o,
  output logic                  loopback_indicator_oe_o,
  output logic                  loopback_internal_o,
  // packet compression pin
  output logic                  packet_compress_out_o,
  output logic                  packet_compress_oe_o,
  // status
  output logic [CFG_W-1:0]      data_config_reg_o,
  output logic [CFG_W-1:0]      data_config_reg_two_o
);

  logic           cfg_written_q;
  logic           cfg2_written_q;
  logic           master_seen_q;
  logic           comp_d;
  anpc_sp_state_t sp_state;

  // first configuration word
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_config_reg_o <= CFG_RST;
    end else if (clk_en_i && data_config_wr_i) begin
      data_config_reg_o <= config_data_i;
    end
  end

  // second configuration word; a rewrite updates user value at once
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_config_reg_two_o <= CFG2_RST;
    end else if (clk_en_i && data_config_two_wr_i) begin
      data_config_reg_two_o <= config_data_i;
    end
  end

  // written flags are sticky: nothing but reset clears them
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_written_q  <= 1'b0;
      cfg2_written_q <= 1'b0;
    end else if (clk_en_i) begin
      if (data_config_wr_i) begin
        cfg_written_q <= 1'b1;
      end
      if (data_config_two_wr_i) begin
        cfg2_written_q <= 1'b1;
      end
    end
  end

  // first bus mastership; kept so a later release keeps the pin driven
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      master_seen_q <= 1'b0;
    end else if (clk_en_i && bus_master_i) begin
      master_seen_q <= 1'b1;
    end
  end

  // loopback request, used inside even while the pin floats
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loopback_internal_o <= 1'b0;
    end else if (clk_en_i) begin
      loopback_internal_o <= line_codec_loop_i;
    end
  end

  // compression level for the current match result
  always_comb begin
    comp_d = packet_compress_out_o;
    if (match_valid_i) begin
      if (match_hit_i) begin
        comp_d = data_config_reg_two_o[COMP_ON_MATCH_BIT];
      end else begin
        comp_d = data_config_reg_two_o[COMP_ON_MISS_BIT];
      end
    end
  end

  // compression pin: level held until the next filter result
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      packet_compress_out_o <= 1'b0;
      packet_compress_oe_o  <= 1'b0;
    end else if (clk_en_i) begin
      packet_compress_out_o <= comp_d;
      // enable lags the write by one edge so the mode bits land first
      packet_compress_oe_o  <= cfg2_written_q;
    end
  end

  // shared pin source selection
  anpc_shared_pin u_shared_pin (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n_i),
    .clk_en_i      (clk_en_i),
    .cfg_written_i (cfg_written_q),
    .ext_bus_sel_i (data_config_reg_o[EXT_BUS_SEL_BIT]),
    .loopback_i    (loopback_internal_o),
    .master_seen_i (master_seen_q),
    .user_val_i    (data_config_reg_two_o[USER_TWO_BIT]),
    .pin_o         (loopback_indicator_out_o),
    .pin_oe_o      (loopback_indicator_oe_o),
    .state_o       (sp_state)
  );

  // checks on the pin behaviour
  logic ebs;
  logic usr;
  assign ebs = data_config_reg_o[EXT_BUS_SEL_BIT];
  assign usr = data_config_reg_two_o[USER_TWO_BIT];

  chk_float_before_cfg:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !cfg_written_q |-> !loopback_indicator_oe_o)
    else $error("shared pin driven before config write");

  chk_loop_drives_high:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      clk_en_i && cfg_written_q && !ebs && loopback_internal_o
      |=> loopback_indicator_oe_o && loopback_indicator_out_o)
    else $error("loopback indicator not driven high");

  chk_select_overrides:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      clk_en_i && cfg_written_q && ebs && master_seen_q && !usr
      && loopback_internal_o |=> !loopback_indicator_out_o)
    else $error("loopback leaks onto user output");

  chk_user_wait_float:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      clk_en_i && ebs && !master_seen_q |=> !loopback_indicator_oe_o)
    else $error("user output driven before mastership");

  chk_user_value:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      clk_en_i && cfg_written_q && ebs && master_seen_q
      |=> loopback_indicator_oe_o
      && loopback_indicator_out_o == $past(usr))
    else $error("user output does not follow config word");

  chk_comp_float:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !cfg2_written_q |=> !packet_compress_oe_o)
    else $error("compression pin driven before config write");

  chk_comp_on_match:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      clk_en_i && match_valid_i && match_hit_i
      |=> packet_compress_out_o
      == $past(data_config_reg_two_o[COMP_ON_MATCH_BIT]))
    else $error("compression wrong on match");

  chk_comp_on_miss:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      clk_en_i && match_valid_i && !match_hit_i
      |=> packet_compress_out_o
      == $past(data_config_reg_two_o[COMP_ON_MISS_BIT]))
    else $error("compression wrong on mismatch");

  chk_internal_copy:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      clk_en_i |=> loopback_internal_o == $past(line_codec_loop_i))
    else $error("internal loopback copy lost");

  chk_select_mux:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      clk_en_i && cfg_written_q && !ebs
      |=> loopback_indicator_oe_o
      && loopback_indicator_out_o == $past(loopback_internal_o))
    else $error("select bit clear but pin not on loopback");

  chk_comp_drives:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      clk_en_i && cfg2_written_q |=> packet_compress_oe_o)
    else $error("compression pin still floating after write");

  chk_comp_holds:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      clk_en_i && !match_valid_i |=> $stable(packet_compress_out_o))
    else $error("compression level moved without a result");

  // main scenarios
  cov_loop_driven:
    cover property (@(posedge clk_i) disable iff (!rst_n_i)
      sp_state == SP_LOOP && loopback_indicator_out_o);
  cov_user_driven:
    cover property (@(posedge clk_i) disable iff (!rst_n_i)
      sp_state == SP_USER && loopback_indicator_oe_o);
  cov_comp_asserted:
    cover property (@(posedge clk_i) disable iff (!rst_n_i)
      packet_compress_oe_o && packet_compress_out_o);
  cov_user_waiting:
    cover property (@(posedge clk_i) disable iff (!rst_n_i)
      sp_state == SP_WAIT && !loopback_indicator_oe_o);

endmodule

// File: verilog/anpc_pkg.sv
/*
  Constants for the auxiliary network pin control block: configuration
  word width, field positions, reset values and shared-pin state codes.
  Assumes the configuration words arrive 16 bits wide from the
  register file on the system clock.
*/
package anpc_pkg;

  // configuration word width
  localparam int unsigned CFG_W = 16;

  // field positions in the first configuration word
  localparam int unsigned EXT_BUS_SEL_BIT = 15;

  // field positions in the second configuration word
  localparam int unsigned COMP_ON_MATCH_BIT = 1;
  localparam int unsigned COMP_ON_MISS_BIT  = 2;
  localparam int unsigned USER_TWO_BIT      = 12;

  // reset values
  localparam logic [15:0] CFG_RST  = 16'h0000;
  localparam logic [15:0] CFG2_RST = 16'h0000;

  // shared pin states
  typedef enum logic [1:0] {
    SP_FLOAT = 2'b00,
    SP_LOOP  = 2'b01,
    SP_WAIT  = 2'b10,
    SP_USER  = 2'b11
  } anpc_sp_state_t;

endpackage

// File: verilog/anpc_shared_pin.sv
/*
  Shared loopback / user output pin: chooses the source of the pin and
  its output enable, both registered.
  Assumes all inputs are flip-flop outputs on clk_i.
*/
`timescale 1ns/1ns
module anpc_shared_pin
  import anpc_pkg::*;
(
  // clock, reset, enable
  input  wire logic      clk_i,
  input  wire logic      rst_n_i,
  input  wire logic      clk_en_i,
  // selection inputs
  input  wire logic      cfg_written_i,
  input  wire logic      ext_bus_sel_i,
  input  wire logic      loopback_i,
  input  wire logic      master_seen_i,
  input  wire logic      user_val_i,
  // pin and its state
  output logic           pin_o,
  output logic           pin_oe_o,
  output anpc_sp_state_t state_o
);

  anpc_sp_state_t state_d;

  // next state follows config; only the float state is left for good
  always_comb begin
    state_d = state_o;
    case (state_o)
      SP_FLOAT: begin
        // mastership may come before the first write: go straight on
        if (cfg_written_i && !ext_bus_sel_i) begin
          state_d = SP_LOOP;
        end else if (cfg_written_i && master_seen_i) begin
          state_d = SP_USER;
        end else if (cfg_written_i) begin
          state_d = SP_WAIT;
        end
      end
      SP_LOOP: begin
        if (ext_bus_sel_i) begin
          state_d = master_seen_i ? SP_USER : SP_WAIT;
        end
      end
      SP_WAIT: begin
        if (!ext_bus_sel_i) begin
          state_d = SP_LOOP;
        end else if (master_seen_i) begin
          state_d = SP_USER;
        end
      end
      SP_USER: begin
        if (!ext_bus_sel_i) begin
          state_d = SP_LOOP;
        end
      end
      default: state_d = SP_FLOAT;
    endcase
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_o <= SP_FLOAT;
    end else if (clk_en_i) begin
      state_o <= state_d;
    end
  end

  // pin value mux: loopback flag or user value, chosen by next state, else 0
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      pin_oe_o <= (state_d == SP_LOOP) || (state_d == SP_USER);
      if (state_d == SP_LOOP) begin
        pin_o <= loopback_i;
      end else if (state_d == SP_USER) begin
        pin_o <= user_val_i;
      end else begin
        pin_o <= 1'b0;
      end
    end
  end

endmodule
